// ===== core/clock_ctl_pins.sv
// control and status pin logic of a clock multiplier, with bus registers
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module clock_ctl_pins #(
	parameter int NUM_OUTPUTS = 4, // outputs that can be stepped
	parameter int FREQ_W = 32 // width of each frequency word
) (
	// bus clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// device pins
	input wire logic device_reset_n,
	input wire logic output_disable,
	input wire logic freq_step_up,
	input wire logic freq_step_down,
	// loop and input monitors, high means the condition holds
	input wire logic pll_lock_det,
	input wire logic [ctl_pins_pkg::NUM_INPUTS-1:0] clock_loss_det,
	input wire logic crystal_loss_det,
	// status pins
	output logic pll_locked_status,
	output logic input_zero_clock_loss_n,
	output logic input_one_clock_loss_n,
	output logic input_two_clock_loss_n,
	output logic input_three_clock_loss_n,
	output logic crystal_signal_loss_n,
	output logic status_change_irq_n,
	output logic irq,
	// output side
	output logic [NUM_OUTPUTS-1:0] clock_out_en,
	output logic [NUM_OUTPUTS-1:0][FREQ_W-1:0] freq_word
);
	import ctl_pins_pkg::*;

	// parameters the logic cannot serve are refused
	if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > (1 << CTRL_SEL_W)) begin : g_bad_n
		$error("NUM_OUTPUTS must lie between 1 and 4");
	end
	if (FREQ_W < 2 || FREQ_W > 32) begin : g_bad_w
		$error("FREQ_W must lie between 2 and 32");
	end

	// map an address to a register identity
	function automatic reg_id_type decode_reg(input logic [31:0] a);
		logic [7:0] o;
		o = a[7:0];
		if (o == OFS_CTRL) begin
			decode_reg = REG_CTRL;
		end else if (o == OFS_STEP) begin
			decode_reg = REG_STEP;
		end else if (o == OFS_STATUS) begin
			decode_reg = REG_STATUS;
		end else if (o == OFS_MASK) begin
			decode_reg = REG_MASK;
		end else if (o == OFS_PINS) begin
			decode_reg = REG_PINS;
		end else if (o >= OFS_FREQ_BASE && o[1:0] == 2'h0 &&
				(o - OFS_FREQ_BASE) < 8'(4 * NUM_OUTPUTS)) begin
			decode_reg = REG_FREQ;
		end else begin
			decode_reg = REG_NONE;
		end
	endfunction

	// frequency word index from an address
	function automatic logic [CTRL_SEL_W-1:0] freq_index(
			input logic [31:0] a);
		logic [7:0] d;
		d = a[7:0] - OFS_FREQ_BASE;
		freq_index = d[CTRL_SEL_W+1:2];
	endfunction

	// device reset acts as a synchronous clear of everything below except the bus slave registers
	logic soft_clr;
	assign soft_clr = ~device_reset_n;

	// ---------------- bus slave ----------------

	logic take; // address phase accepted this edge
	logic wr_pend_r; // write data phase in progress
	logic [31:0] wr_addr_r; // address of that write
	logic rd_wait_r; // one wait state for reads
	logic [31:0] rd_addr_r; // address of pending read
	logic [31:0] hrdata_r; // registered read data
	reg_id_type wr_id; // decoded write target
	reg_id_type rd_id; // decoded read target

	assign take = hsel && hready && htrans == HTRANS_NONSEQ;
	assign wr_id = decode_reg(wr_addr_r);
	assign rd_id = decode_reg(rd_addr_r);

	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h0000_0000;
		end else if (hready) begin
			wr_pend_r <= take && hwrite;
			if (take && hwrite) begin
				wr_addr_r <= haddr;
			end
		end
	end

	// address phase capture for reads, then one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait_r <= 1'b0;
			rd_addr_r <= 32'h0000_0000;
		end else if (rd_wait_r) begin
			rd_wait_r <= 1'b0;
		end else if (take && !hwrite) begin
			rd_wait_r <= 1'b1;
			rd_addr_r <= haddr;
		end
	end

	// writes need no wait, reads one, errors never
	assign hreadyout = ~rd_wait_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// one-cycle write strobes per register
	logic wr_ctrl, wr_step, wr_status, wr_mask;
	assign wr_ctrl = wr_pend_r && wr_id == REG_CTRL;
	assign wr_step = wr_pend_r && wr_id == REG_STEP;
	assign wr_status = wr_pend_r && wr_id == REG_STATUS;
	assign wr_mask = wr_pend_r && wr_id == REG_MASK;

	// ---------------- configuration registers ----------------

	logic [CTRL_SEL_W-1:0] sel_r; // output hit by step pins
	logic [FREQ_W-1:0] step_r; // size of one frequency step

	// output select
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_r <= SEL_RST;
		end else if (soft_clr) begin
			sel_r <= SEL_RST;
		end else if (wr_ctrl) begin
			sel_r <= hwdata[CTRL_SEL_LSB +: CTRL_SEL_W];
		end
	end

	// step size
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_r <= STEP_RST[FREQ_W-1:0];
		end else if (soft_clr) begin
			step_r <= STEP_RST[FREQ_W-1:0];
		end else if (wr_step) begin
			step_r <= hwdata[FREQ_W-1:0];
		end
	end

	// ---------------- frequency stepping ----------------

	logic [1:0] step_rise; // bit 0 up, bit 1 down

	// undriven pins are pulled low on the board, so idle means no step
	pin_rise #(
		.W(2)
	) u_step_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(soft_clr),
		.level({freq_step_down, freq_step_up}),
		.rise(step_rise)
	);

	logic [NUM_OUTPUTS-1:0][FREQ_W-1:0] freq_r; // per output words

	// one word per output; bus write wins over a pin step
	for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_freq
		logic hit; // this output is the step target
		logic bus_wr; // bus writes this word
		assign hit = sel_r == CTRL_SEL_W'(i);
		assign bus_wr = wr_pend_r && wr_id == REG_FREQ &&
			freq_index(wr_addr_r) == CTRL_SEL_W'(i);
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				freq_r[i] <= FREQ_RST[FREQ_W-1:0];
			end else if (soft_clr) begin
				freq_r[i] <= FREQ_RST[FREQ_W-1:0];
			end else if (bus_wr) begin
				freq_r[i] <= hwdata[FREQ_W-1:0];
			end else if (hit && step_rise == 2'h1) begin
				freq_r[i] <= freq_r[i] + step_r;
			end else if (hit && step_rise == 2'h2) begin
				freq_r[i] <= freq_r[i] - step_r;
			end
		end
	end

	assign freq_word = freq_r;

	// ---------------- output enables ----------------

	logic out_en_r; // outputs allowed to run

	// outputs run only when out of reset and not disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_en_r <= 1'b0;
		end else if (soft_clr) begin
			out_en_r <= 1'b0;
		end else begin
			out_en_r <= ~output_disable;
		end
	end

	// the pin also gates directly so reset blanks at once
	assign clock_out_en = {NUM_OUTPUTS{out_en_r & device_reset_n}};

	// ---------------- status pins ----------------

	logic lock_r; // registered lock state
	logic [NUM_INPUTS-1:0] loss_n_r; // low while an input is lost
	logic xtal_n_r; // low while crystal is lost
	logic mon_valid_r; // history is meaningful

	// mirror the monitors onto the pins; after reset show no lock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_r <= 1'b0;
			loss_n_r <= '1;
			xtal_n_r <= 1'b1;
		end else if (soft_clr) begin
			lock_r <= 1'b0;
			loss_n_r <= '1;
			xtal_n_r <= 1'b1;
		end else begin
			lock_r <= pll_lock_det;
			loss_n_r <= ~clock_loss_det;
			xtal_n_r <= ~crystal_loss_det;
		end
	end

	assign pll_locked_status = lock_r;
	assign input_zero_clock_loss_n = loss_n_r[0];
	assign input_one_clock_loss_n = loss_n_r[1];
	assign input_two_clock_loss_n = loss_n_r[2];
	assign input_three_clock_loss_n = loss_n_r[3];
	assign crystal_signal_loss_n = xtal_n_r;

	// the first sample after reset is no change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon_valid_r <= 1'b0;
		end else if (soft_clr) begin
			mon_valid_r <= 1'b0;
		end else begin
			mon_valid_r <= 1'b1;
		end
	end

	// ---------------- events and interrupt ----------------

	logic [EV_W-1:0] ev_set; // one-cycle change pulses
	logic [EV_W-1:0] ev_status; // sticky bits
	logic [EV_W-1:0] ev_mask; // mask bits

	// any change of a monitored level is an event
	always_comb begin
		ev_set = '0;
		if (mon_valid_r) begin
			ev_set[EV_LOCK] = lock_r ^ pll_lock_det;
			ev_set[EV_LOSS_LSB +: NUM_INPUTS] = loss_n_r ^ ~clock_loss_det;
			ev_set[EV_XTAL] = xtal_n_r ^ ~crystal_loss_det;
		end
	end

	event_status #(
		.W(EV_W),
		.MASK_INIT(MASK_RST)
	) u_events (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(soft_clr),
		.ev_set(ev_set),
		.clr_wr(wr_status),
		.mask_wr(wr_mask),
		.wdata(hwdata[EV_W-1:0]),
		.status(ev_status),
		.mask(ev_mask),
		.irq(irq)
	);

	assign status_change_irq_n = ~irq;

	// ---------------- read data ----------------

	logic [31:0] rd_mux; // value of the addressed register

	// select read value, holes read as zero
	always_comb begin
		rd_mux = UNMAPPED_DATA;
		case (rd_id)
			REG_CTRL: begin
				rd_mux[CTRL_SEL_LSB +: CTRL_SEL_W] = sel_r;
			end
			REG_STEP: begin
				rd_mux[FREQ_W-1:0] = step_r;
			end
			REG_STATUS: begin
				rd_mux[EV_W-1:0] = ev_status;
			end
			REG_MASK: begin
				rd_mux[EV_W-1:0] = ev_mask;
			end
			REG_PINS: begin
				rd_mux[PIN_LOCK] = lock_r;
				rd_mux[PIN_LOSS_LSB +: NUM_INPUTS] = loss_n_r;
				rd_mux[PIN_XTAL] = xtal_n_r;
				rd_mux[PIN_DISABLE] = output_disable;
				rd_mux[PIN_OUT_EN] = out_en_r;
			end
			REG_FREQ: begin
				rd_mux[FREQ_W-1:0] = freq_r[freq_index(rd_addr_r)];
			end
			default: begin
				rd_mux = UNMAPPED_DATA;
			end
		endcase
	end

	// data latched at the end of the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_wait_r) begin
			hrdata_r <= rd_mux;
		end
	end

endmodule
`default_nettype wire

// ===== core/ctl_pins_pkg.sv
// shared constants for the clock control and status pin block
package ctl_pins_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STEP = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_PINS = 8'h10;
	localparam logic [7:0] OFS_FREQ_BASE = 8'h20;

	// control register fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_SEL_W = 2;

	// status and mask layout, one event bit each
	localparam int EV_LOCK = 0;
	localparam int EV_LOSS_LSB = 1;
	localparam int EV_XTAL = 5;
	localparam int EV_W = 6;

	// pin readback layout
	localparam int PIN_LOCK = 0;
	localparam int PIN_LOSS_LSB = 1;
	localparam int PIN_XTAL = 5;
	localparam int PIN_DISABLE = 6;
	localparam int PIN_OUT_EN = 7;

	// reset values
	localparam logic [CTRL_SEL_W-1:0] SEL_RST = 2'h0;
	localparam logic [31:0] STEP_RST = 32'h0000_0001;
	localparam logic [31:0] FREQ_RST = 32'h0000_0000;
	localparam logic [EV_W-1:0] MASK_RST = 6'h00;

	// number of monitored clock inputs, one per loss pin
	localparam int NUM_INPUTS = 4;

	// read answer for a hole in the map
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// htrans codes of the bus
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// decoded register identities
	typedef enum {
		REG_CTRL,
		REG_STEP,
		REG_STATUS,
		REG_MASK,
		REG_PINS,
		REG_FREQ,
		REG_NONE
	} reg_id_type;

endpackage

// ===== core/event_status.sv
// sticky event status with write-one-to-clear, mask and interrupt
`timescale 1ns/100ps
`default_nettype none
module event_status #(
	parameter int W = 6,
	parameter logic [W-1:0] MASK_INIT = '0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	input wire logic [W-1:0] ev_set,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);

	logic [W-1:0] status_r; // sticky event bits
	logic [W-1:0] mask_r; // one enables the bit onto irq

	// sticky bits, a new event beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r <= '0;
		end else if (clr) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~({W{clr_wr}} & wdata)) | ev_set;
		end
	end

	// mask register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_r <= MASK_INIT;
		end else if (clr) begin
			mask_r <= MASK_INIT;
		end else if (mask_wr) begin
			mask_r <= wdata;
		end
	end

	assign status = status_r;
	assign mask = mask_r;
	assign irq = |(status_r & mask_r);

endmodule
`default_nettype wire

// ===== core/pin_rise.sv
// rising edge detector for synchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_rise #(
	parameter int W = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);

	// last sampled level; starts high so a pin held high gives no step
	logic [W-1:0] prev_r;

	// keep one sample of history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_r <= '1;
		end else if (clr) begin
			prev_r <= '1;
		end else begin
			prev_r <= level;
		end
	end

	// one-cycle pulse per low to high change
	assign rise = level & ~prev_r & {W{~clr}};

endmodule
`default_nettype wire

// ===== verif/board_pins.sv
// board side model driving the step pins of the clock block
`timescale 1ns/100ps
`default_nettype none
module board_pins (
	input wire logic hclk,
	output logic freq_step_up,
	output logic freq_step_down
);
	// idle low, as the board pull-downs leave them
	initial begin
		freq_step_up = 1'b0;
		freq_step_down = 1'b0;
	end
	// one pulse, two cycles high then two low, {up, down}
	task automatic pulse(input logic [1:0] ud);
		@(posedge hclk);
		freq_step_up <= ud[1];
		freq_step_down <= ud[0];
		repeat (2) @(posedge hclk);
		freq_step_up <= 1'b0;
		freq_step_down <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
endmodule
`default_nettype wire

// ===== verif/clock_ctl_pins_tb.sv
// self-checking bench for the clock control and status pin block
`timescale 1ns/100ps
`default_nettype none
module clock_ctl_pins_tb;
	import ctl_pins_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd, ex;
	logic [1:0] htrans;
	logic dev_n, dis, up, dn, lock_det, xtal_det;
	logic [3:0] loss_det, oe;
	logic lk, l0, l1, l2, l3, xl, irq_n, irq;
	logic [3:0][31:0] fw;
	logic [7:0] adr [5];
	logic [31:0] rst_v [5];
	int fail_count, checks_done;
	clock_ctl_pins clock_ctl_pins_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.device_reset_n(dev_n), .output_disable(dis),
		.freq_step_up(up), .freq_step_down(dn), .pll_lock_det(lock_det),
		.clock_loss_det(loss_det), .crystal_loss_det(xtal_det),
		.pll_locked_status(lk), .input_zero_clock_loss_n(l0),
		.input_one_clock_loss_n(l1), .input_two_clock_loss_n(l2),
		.input_three_clock_loss_n(l3), .crystal_signal_loss_n(xl),
		.status_change_irq_n(irq_n), .irq(irq), .clock_out_en(oe),
		.freq_word(fw));
	board_pins board_pins_inst (.hclk(hclk), .freq_step_up(up),
		.freq_step_down(dn));
	// compare one value, count and report
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one single ahb-lite word transfer
	task automatic ahb(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// cut a hang short
	initial begin
		repeat (5000) @(posedge hclk);
		fail_count++;
		$display("[FAIL] watchdog expected end seen hang");
		tally_and_finish();
	end
	initial begin
		fail_count = 0;
		checks_done = 0;
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{dis, lock_det, loss_det, xtal_det} = '0;
		dev_n = 1'b1;
		adr = '{OFS_CTRL, OFS_STEP, OFS_MASK, OFS_FREQ_BASE, 8'h40};
		rst_v = '{32'h0, STEP_RST, 32'h0, FREQ_RST, UNMAPPED_DATA};
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// register defaults and an unmapped hole
		for (int i = 0; i < 5; i++) begin
			ahb(1'b0, {24'h0, adr[i]}, 32'h0);
			chk("reset value", rst_v[i], rd);
		end
		chk("pins idle", 32'h3e, {xl, l3, l2, l1, l0, lk});
		$display("test reset done");
		// output disable pin
		chk("outputs on", 32'hf, oe);
		dis <= 1'b1;
		repeat (2) @(posedge hclk);
		chk("outputs off", 32'h0, oe);
		dis <= 1'b0;
		$display("test disable done");
		// monitors reach their status pins
		for (int i = 0; i < 4; i++) begin
			loss_det <= 4'h1 << i;
			lock_det <= i[0];
			xtal_det <= i[1];
			ex = {26'h0, !i[1], ~(4'h1 << i), i[0]};
			repeat (2) @(posedge hclk);
			chk("status pins", ex, {xl, l3, l2, l1, l0, lk});
		end
		$display("test status pins done");
		// interrupt raise, clear and mask; a write lands at the edge
		// the task returns on, so look one edge later
		ahb(1'b1, OFS_MASK, 32'h3f);
		@(posedge hclk);
		chk("irq pending", 32'h0, irq_n);
		ahb(1'b1, OFS_STATUS, 32'h3f);
		@(posedge hclk);
		chk("irq cleared", 32'h1, irq_n);
		ahb(1'b1, OFS_MASK, 32'h1);
		lock_det <= ~lock_det;
		repeat (2) @(posedge hclk);
		chk("irq low", 32'h0, irq_n);
		chk("irq level", 32'h1, irq);
		ahb(1'b0, OFS_STATUS, 32'h0);
		chk("status lock", 32'h1, rd);
		ahb(1'b1, OFS_STATUS, 32'h1);
		@(posedge hclk);
		chk("irq w1c", 32'h1, irq_n);
		ahb(1'b1, OFS_MASK, 32'h0);
		lock_det <= ~lock_det;
		repeat (2) @(posedge hclk);
		chk("irq masked", 32'h1, irq_n);
		$display("test interrupt done");
		// steps on each selected output
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, OFS_CTRL, i);
			ahb(1'b1, OFS_STEP, 5 + i);
			board_pins_inst.pulse(2'b10);
			chk("step up", 5 + i, fw[i]);
			board_pins_inst.pulse(2'b01);
			board_pins_inst.pulse(2'b01);
			chk("step down wrap", 32'h0 - (5 + i), fw[i]);
			board_pins_inst.pulse(2'b11);
			chk("opposed steps", 32'h0 - (5 + i), fw[i]);
		end
		$display("test steps done");
		// device reset pin restores defaults
		ahb(1'b1, OFS_STEP, 32'h9);
		dev_n <= 1'b0;
		@(posedge hclk);
		chk("outputs in reset", 32'h0, oe);
		repeat (2) @(posedge hclk);
		dev_n <= 1'b1;
		ahb(1'b0, OFS_STEP, 32'h0);
		chk("step default", STEP_RST, rd);
		chk("okay response", 32'h0, hresp);
		chk("words cleared", 32'h0, {31'h0, |fw});
		$display("test device reset done");
		tally_and_finish();
	end
endmodule
bind clock_ctl_pins ctl_pins_props #(.NUM_OUTPUTS(NUM_OUTPUTS),
	.FREQ_W(FREQ_W)) ctl_pins_props_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout),
	.device_reset_n(device_reset_n), .output_disable(output_disable),
	.freq_step_up(freq_step_up), .freq_step_down(freq_step_down),
	.pll_lock_det(pll_lock_det), .clock_loss_det(clock_loss_det),
	.crystal_loss_det(crystal_loss_det),
	.pll_locked_status(pll_locked_status),
	.input_zero_clock_loss_n(input_zero_clock_loss_n),
	.input_one_clock_loss_n(input_one_clock_loss_n),
	.input_two_clock_loss_n(input_two_clock_loss_n),
	.input_three_clock_loss_n(input_three_clock_loss_n),
	.crystal_signal_loss_n(crystal_signal_loss_n),
	.status_change_irq_n(status_change_irq_n), .irq(irq),
	.clock_out_en(clock_out_en), .freq_word(freq_word));
`default_nettype wire

// ===== verif/ctl_pins_props.sv
// assertions on the pin and bus behaviour of the clock control block
`timescale 1ns/100ps
`default_nettype none
module ctl_pins_props #(
	parameter int NUM_OUTPUTS = 4,
	parameter int FREQ_W = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic device_reset_n,
	input wire logic output_disable,
	input wire logic freq_step_up,
	input wire logic freq_step_down,
	input wire logic pll_lock_det,
	input wire logic [ctl_pins_pkg::NUM_INPUTS-1:0] clock_loss_det,
	input wire logic crystal_loss_det,
	input wire logic pll_locked_status,
	input wire logic input_zero_clock_loss_n,
	input wire logic input_one_clock_loss_n,
	input wire logic input_two_clock_loss_n,
	input wire logic input_three_clock_loss_n,
	input wire logic crystal_signal_loss_n,
	input wire logic status_change_irq_n,
	input wire logic irq,
	input wire logic [NUM_OUTPUTS-1:0] clock_out_en,
	input wire logic [NUM_OUTPUTS-1:0][FREQ_W-1:0] freq_word
);
	import ctl_pins_pkg::*;
	logic up_q_r, dn_q_r, wr_dp_r; // last pin levels, write data phase
	logic up_rise, dn_rise;
	assign up_rise = freq_step_up && !up_q_r;
	assign dn_rise = freq_step_down && !dn_q_r;
	// remember pin levels and which cycle carries write data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_q_r <= 1'b0;
			dn_q_r <= 1'b0;
			wr_dp_r <= 1'b0;
		end else begin
			up_q_r <= freq_step_up;
			dn_q_r <= freq_step_down;
			wr_dp_r <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd_taken;
		hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence s_rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (s_rd_taken |=> s_rd_answer)
		else $error("read data phase length wrong");
	a_reset_outs_off: assert property (
		!device_reset_n |-> clock_out_en == '0)
		else $error("outputs on during device reset");
	a_disable_outs: assert property (
		device_reset_n && $past(device_reset_n) && $past(hresetn)
		|-> clock_out_en == {NUM_OUTPUTS{!$past(output_disable)}})
		else $error("output enable does not follow disable pin");
	a_lock_follows: assert property (
		$past(hresetn) && $past(device_reset_n)
		|-> pll_locked_status == $past(pll_lock_det))
		else $error("lock pin wrong");
	a_loss_follows: assert property (
		$past(hresetn) && $past(device_reset_n)
		|-> {input_three_clock_loss_n, input_two_clock_loss_n,
		input_one_clock_loss_n, input_zero_clock_loss_n}
		== ~$past(clock_loss_det))
		else $error("input loss pins wrong");
	a_crystal_follows: assert property (
		$past(hresetn) && $past(device_reset_n)
		|-> crystal_signal_loss_n == !$past(crystal_loss_det))
		else $error("crystal loss pin wrong");
	a_reset_clears: assert property (
		!device_reset_n |=> freq_word == '0 && !pll_locked_status && !irq)
		else $error("device reset left state behind");
	a_irq_pin_low: assert property (
		status_change_irq_n == !irq)
		else $error("interrupt pin not inverse of irq");
	a_word_cause: assert property (
		$changed(freq_word) |-> $past(wr_dp_r || !device_reset_n
		|| up_rise || dn_rise))
		else $error("frequency word changed without cause");
	a_both_no_step: assert property (
		up_rise && dn_rise && !wr_dp_r && device_reset_n
		|=> $stable(freq_word))
		else $error("opposing steps changed a word");
endmodule
`default_nettype wire
